// ==== prs_pin_reset_seq.sv ====
// pin reset sequencer: sequences the external reset pin into core resets
//
// Overview of operation
// R1: five reset sources, pin and brown-out hardware
// R2: pin low holds pins, cpu, registers reset
// R3: pin low also resets oscillator circuit
// R4: after pin reset on-chip oscillator clocks cpu
// R5: release cpu and registers on pin rise
// R6: cpu fetches reset vector after release
// R7: internal ram never cleared by pin reset
// R8: reset during ram write marks ram undefined
// R9: supervisor holds pin low for settle time
// R10: power-on: supply then settle waits before release
// R11: pin synchronised; assert fast, release synchronously
// R12: settle count parameter; flag too-short pulses
`timescale 1ns/1ps
`default_nettype none
`include "prs_consts.svh"
module prs_pin_reset_seq
   import prs_pkg::*;
#(
   parameter int SETTLE_CYC = `PRS_OSC_SETTLE_CYC,
   parameter int VEC_AW     = `PRS_VEC_AW
) (
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                srst_i,
   // external reset pin, active low, asynchronous
   input  wire logic                reset_pin_n_i,
   // other reset requests from the core, same clock, one-cycle pulses or levels
   input  wire logic                brownout_rst_i,
   input  wire logic                software_rst_i,
   input  wire logic                watchdog_rst_i,
   input  wire logic                oscstop_rst_i,
   // ram write in progress, same clock
   input  wire logic                ram_wr_busy_i,
   // on-chip oscillator running flag
   input  wire logic                osc_running_i,
   // reset outputs
   output prs_pkg::prs_rst_bus_t    rst_o,
   // vector fetch request and address
   output logic                     vec_fetch_o,
   output logic [VEC_AW-1:0]        vec_addr_o,
   // status
   output prs_pkg::prs_stat_t       stat_o
);
   import prs_pkg::*;

   // elaboration check on parameters
   if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << `PRS_CNT_W) || VEC_AW < 1) begin : g_bad
      $error("prs_pin_reset_seq: unsupported parameter value");
   end

   localparam logic [`PRS_CNT_W-1:0] SETTLE_MAX = `PRS_CNT_W'(SETTLE_CYC - 1);

   logic pin_n_s;                  // synchronised pin level, low while pin is low
   logic pin_low_s;                // synchronised pin, high while pin is low
   logic pin_low_d_r;              // previous sample for edge detection
   prs_state_t state_r, state_nxt;
   logic [`PRS_CNT_W-1:0] cnt_r, cnt_nxt;         // settle counter
   logic [`PRS_CNT_W-1:0] pulse_r, pulse_nxt;     // pin low length, saturating
   logic [`PRS_SRC_N-1:0] cause_r, cause_nxt;     // last reset cause
   logic ram_undef_r, ram_undef_nxt;              // sticky ram-undefined flag
   logic short_r, short_nxt;                      // pulse shorter than settle
   logic rst_req;                                 // any source asking for reset
   logic pin_rise;                                // synchronised low-to-high

   // pin synchroniser; the raw pin goes straight into the first flop and is
   // inverted only after the second; reset state reads as pin low so core stays held
   prs_sync #(
      .RESET_VAL(1'b0)
   ) u_pin_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i   (srst_i),
      .async_i  (reset_pin_n_i),    // R11
      .sync_o   (pin_n_s)
   );
   assign pin_low_s = ~pin_n_s;     // R11

   // hardware sources are pin and brown-out; the others are soft resets
   function automatic logic is_hw(input logic [`PRS_SRC_N-1:0] c);
      is_hw = c[`PRS_SRC_PIN] | c[`PRS_SRC_BROWNOUT];   // R1
   endfunction

   assign rst_req  = pin_low_s | brownout_rst_i | software_rst_i
                     | watchdog_rst_i | oscstop_rst_i;   // R1
   assign pin_rise = pin_low_d_r & ~pin_low_s;           // R5

   // next-state for the sequencer
   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      pulse_nxt     = pulse_r;
      cause_nxt     = cause_r;
      ram_undef_nxt = ram_undef_r;
      short_nxt     = short_r;
      if (rst_req) begin
         // any source drops straight back to hold, no clock count needed
         state_nxt = PRS_HOLD;                           // R11
         cnt_nxt   = '0;
         cause_nxt = {oscstop_rst_i, watchdog_rst_i, software_rst_i,
                      brownout_rst_i, pin_low_s};        // R1
         // reset landing on a ram write spoils the ram contents
         if (ram_wr_busy_i && state_r == PRS_RUN) begin
            ram_undef_nxt = 1'b1;                        // R8
         end
         if (pin_low_s) begin
            if (state_r != PRS_HOLD || !pin_low_d_r) begin
               pulse_nxt = `PRS_CNT_W'(1);
            end else if (pulse_r != '1) begin
               pulse_nxt = pulse_r + `PRS_CNT_W'(1);
            end
         end
      end else begin
         case (state_r)
            PRS_HOLD: begin
               // pin rise ends the pulse; judge its length
               if (pin_rise) begin
                  short_nxt = (pulse_r <= SETTLE_MAX);   // R12
               end
               state_nxt = PRS_SETTLE;
            end
            PRS_SETTLE: begin
               // wait for the on-chip oscillator to settle
               if (osc_running_i && cnt_r == SETTLE_MAX) begin
                  state_nxt = PRS_VECTOR;                // R4
               end else if (cnt_r != SETTLE_MAX) begin
                  cnt_nxt = cnt_r + `PRS_CNT_W'(1);
               end
            end
            PRS_VECTOR: begin
               state_nxt = PRS_RUN;                      // R6
            end
            PRS_RUN: begin
               state_nxt = PRS_RUN;
            end
            default: begin
               state_nxt = PRS_HOLD;
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_r     <= PRS_HOLD;
         cnt_r       <= '0;
         // reset counts as a long pulse, so the forced rise after reset never flags short
         pulse_r     <= '1;
         cause_r     <= `PRS_SRC_N'(1);
         ram_undef_r <= 1'b0;
         short_r     <= 1'b0;
         pin_low_d_r <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         pulse_r     <= pulse_nxt;
         cause_r     <= cause_nxt;
         ram_undef_r <= ram_undef_nxt;
         short_r     <= short_nxt;
         pin_low_d_r <= pin_low_s;
      end
   end

   // reset bus; pins follow the pin directly, core waits for settle
   always_comb begin
      rst_o.pins_rst       = pin_low_s | (state_r == PRS_HOLD);         // R2
      rst_o.cpu_rst        = (state_r != PRS_RUN) && (state_r != PRS_VECTOR); // R2 R5
      rst_o.periph_rst     = (state_r == PRS_HOLD) || (state_r == PRS_SETTLE); // R2
      rst_o.osc_rst        = (state_r == PRS_HOLD) && is_hw(cause_r);  // R3
      rst_o.osc_sel_onchip = 1'b1;   // on-chip oscillator after every reset R4
   end

   // vector request is a one-cycle pulse; ram is never touched here R7
   assign vec_fetch_o = (state_r == PRS_VECTOR);                      // R6
   assign vec_addr_o  = VEC_AW'(`PRS_VEC_ADDR);
   assign stat_o.cause         = cause_r;
   assign stat_o.hw_reset      = is_hw(cause_r);
   assign stat_o.ram_undefined = ram_undef_r;
   assign stat_o.short_pulse   = short_r;

   // vector fetch comes exactly one cycle after settle completes
   a_vec_after_settle: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R4
      (state_r == PRS_SETTLE && !rst_req && osc_running_i && cnt_r == SETTLE_MAX)
      |=> vec_fetch_o)
      else $error("vector fetch missing after settle");
   // settle never ends while the oscillator is still stopped
   a_osc_wait: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R4
      (state_r == PRS_SETTLE && !osc_running_i) |=> !vec_fetch_o)
      else $error("settle ended before oscillator ran");
   // cpu held while synchronised pin is low
   a_cpu_held_low: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R2
      pin_low_s |=> rst_o.cpu_rst && rst_o.periph_rst && rst_o.pins_rst)
      else $error("core not held during pin low");
   // oscillator circuit reset during pin reset
   a_osc_reset_pin: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R3
      pin_low_s |=> rst_o.osc_rst)
      else $error("oscillator not reset by pin");
   // release follows a pin rise through settle then vector
   a_release_order: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R5
      $fell(rst_o.cpu_rst) |-> $past(state_r) == PRS_SETTLE)
      else $error("cpu released outside settle exit");
   // peripheral registers come out of reset only together with the vector fetch
   a_periph_release: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R5
      $fell(rst_o.periph_rst) |-> vec_fetch_o)
      else $error("registers released outside vector fetch");
   // vector fetch is one cycle and cpu runs right after
   a_vec_pulse: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R6
      vec_fetch_o && !rst_req |=> !vec_fetch_o && !rst_o.cpu_rst)
      else $error("vector fetch not single pulse");
   // settle lasts at least the settle count
   a_settle_len: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R12
      $rose(vec_fetch_o) |-> $past(cnt_r) == SETTLE_MAX)
      else $error("settle shorter than count");
   // ram flag set when reset hits a running write
   a_ram_undef: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R8
      (rst_req && ram_wr_busy_i && state_r == PRS_RUN) |=> stat_o.ram_undefined)
      else $error("ram undefined flag not set");
   // pin low makes pin the recorded cause, a hardware reset
   a_cause_pin: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R1
      pin_low_s |=> stat_o.cause[`PRS_SRC_PIN] && stat_o.hw_reset)
      else $error("pin cause not recorded");
   // any request forces hold within one cycle, no counting
   a_fast_assert: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R11
      rst_req |=> state_r == PRS_HOLD)
      else $error("reset request not immediate");
endmodule
`default_nettype wire

// ==== prs_consts.svh ====
// timing counts, widths and encodings for the pin reset sequencer
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
// on-chip oscillator settling interval in ns, and the clock period in ns
`define PRS_OSC_SETTLE_NS     1000
`define PRS_CLK_PERIOD_NS     100
// settle count in cycles, least time rounded up
`define PRS_OSC_SETTLE_CYC    ((`PRS_OSC_SETTLE_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
// counter width for settle and pulse-length counters
`define PRS_CNT_W             16
// reset vector address width and default vector location
`define PRS_VEC_AW            20
`define PRS_VEC_ADDR          20'hffffc
// reset source encodings, one bit each in the cause word
`define PRS_SRC_PIN           0
`define PRS_SRC_BROWNOUT      1
`define PRS_SRC_SOFTWARE      2
`define PRS_SRC_WATCHDOG      3
`define PRS_SRC_OSCSTOP       4
`define PRS_SRC_N             5
`endif

// ==== prs_pkg.sv ====
// types shared by the pin reset sequencer
`include "prs_consts.svh"
package prs_pkg;
   // sequencer phases
   typedef enum logic [2:0] {
      PRS_HOLD,
      PRS_SETTLE,
      PRS_VECTOR,
      PRS_RUN
   } prs_state_t;
   // reset outputs that travel together toward the core
   typedef struct packed {
      logic pins_rst;
      logic cpu_rst;
      logic periph_rst;
      logic osc_rst;
      logic osc_sel_onchip;
   } prs_rst_bus_t;
   // status toward the core
   typedef struct packed {
      logic [`PRS_SRC_N-1:0] cause;
      logic                  hw_reset;
      logic                  ram_undefined;
      logic                  short_pulse;
   } prs_stat_t;
endpackage

// ==== prs_sync.sv ====
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module prs_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   // pin and synchronised level
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_r;   // first stage, read only by the second
   logic sync_r;   // second stage
   // two stages; reset value is a constant
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         meta_r <= RESET_VAL;
         sync_r <= RESET_VAL;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end
   assign sync_o = sync_r;
endmodule
`default_nettype wire

// ==== prs_supervisor_model.sv ====
// board reset supervisor model that drives the active-low reset pin
`timescale 1ns/1ps
`default_nettype none
module prs_supervisor_model #(
   parameter int SUPPLY_CYC = 6, // supply_settle_wait in clocks, plain default
   parameter int SETTLE_CYC = 4  // oscillator_settle_wait in clocks
) (
   // clock
   input  wire logic        ref_clk_i,
   // pulse request from the bench
   input  wire logic        go_i,
   input  wire logic [15:0] len_i,
   // pin and status
   output logic             reset_pin_n_o,
   output logic             busy_o
);
   int cnt; // low cycles still to go
   // power-on: pin low while supply ramps, then both settle waits
   initial begin
      reset_pin_n_o = 1'b0;
      busy_o = 1'b1;
      cnt = SUPPLY_CYC + SETTLE_CYC;
   end
   // hold pin low for the asked count; a short count is the bench's own fault injection
   always @(posedge ref_clk_i) begin
      if (go_i && !busy_o) begin
         reset_pin_n_o <= 1'b0;
         busy_o <= 1'b1;
         cnt <= len_i;
      end else if (busy_o) begin
         if (cnt <= 1) begin
            reset_pin_n_o <= 1'b1;
            busy_o <= 1'b0;
         end
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// ==== pin_reset_sequencer_tb.sv ====
// self-checking bench for the pin reset sequencer
`timescale 1ns/1ps
`default_nettype none
module pin_reset_sequencer_tb;
   import prs_pkg::*;
   localparam int SC = 4; // shortened settle count keeps the run brief
   logic ref_clk_i, srst_i, pin_n, bo_rst, sw_rst, wd_rst, os_rst;
   logic ram_busy, osc_run, go, busy, vf;
   logic [15:0] len;           // pulse length toward the supervisor
   prs_rst_bus_t rst;          // reset outputs
   prs_stat_t st;              // status word
   logic [19:0] va;            // vector address
   int err_count, cmp_count;   // mismatches and comparisons
   prs_pin_reset_seq #(.SETTLE_CYC(SC), .VEC_AW(20)) dut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reset_pin_n_i(pin_n),
      .brownout_rst_i(bo_rst), .software_rst_i(sw_rst), .watchdog_rst_i(wd_rst),
      .oscstop_rst_i(os_rst), .ram_wr_busy_i(ram_busy), .osc_running_i(osc_run),
      .rst_o(rst), .vec_fetch_o(vf), .vec_addr_o(va), .stat_o(st));
   prs_supervisor_model #(.SETTLE_CYC(SC)) sup (
      .ref_clk_i(ref_clk_i), .go_i(go), .len_i(len), .reset_pin_n_o(pin_n), .busy_o(busy));
   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // a pin pulse shorter than the settle count must be flagged
   function automatic logic exp_short(input int l);
      return l < SC;
   endfunction
   // bounded wait for the vector fetch pulse, sampled after the edge settles
   task automatic wait_vec(output int n);
      n = 0;
      while (vf !== 1'b1 && n < 200) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
   endtask
   // one pin pulse, then the whole release walk
   task automatic pin_pulse(input int l, input logic exp_short);
      int n;
      @(posedge ref_clk_i);
      go <= 1'b1;
      len <= l[15:0];
      @(posedge ref_clk_i);
      go <= 1'b0;
      n = 0;
      while (rst !== 5'h1f && n < 10) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check(rst, 5'h1f);
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check(rst.cpu_rst, 1'b1);
      wait_vec(n);
      check(n < 200, 1'b1);
      check(n >= SC, 1'b1);
      check(rst.cpu_rst, 1'b0);
      check(rst.periph_rst, 1'b0);
      check(va, 20'hffffc);
      check(st.cause[0], 1'b1);
      check(st.hw_reset, 1'b1);
      check(st.short_pulse, exp_short);
      $display("test pin pulse len=%0d done", l);
   endtask
   // level request from one of the other sources, bit index b
   task automatic src_req(input int b);
      int n;
      @(posedge ref_clk_i);
      {os_rst, wd_rst, sw_rst, bo_rst} <= 4'h1 << (b - 1);
      repeat (2) @(posedge ref_clk_i);
      #1;
      check(rst.osc_rst, b == 1);
      check(rst.cpu_rst, 1'b1);
      @(posedge ref_clk_i);
      {os_rst, wd_rst, sw_rst, bo_rst} <= 4'h0;
      wait_vec(n);
      check(n < 200, 1'b1);
      check(st.cause[b], 1'b1);
      check(st.hw_reset, b == 1);
      $display("test source %0d done", b);
   endtask
   // verdict and end of run
   task automatic summarize;
      $display("comparisons=%0d mismatches=%0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // 10 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   // watchdog: the tests need well under a thousand cycles
   initial begin
      #(100 * 5000);
      err_count++;
      $display("watchdog expired");
      summarize;
   end
   // main sequence
   initial begin
      int n;
      int l;
      srst_i = 1'b1;
      {os_rst, wd_rst, sw_rst, bo_rst} = 4'h0;
      ram_busy = 1'b0;
      osc_run = 1'b1;
      go = 1'b0;
      len = 16'h0;
      err_count = 0;
      cmp_count = 0;
      void'($urandom(39177));
      repeat (12) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      wait_vec(n);
      check(n < 200, 1'b1);
      $display("test power on done");
      // corners: exact settle count, one short, single cycle
      pin_pulse(SC, 1'b0);
      pin_pulse(SC - 1, 1'b1);
      pin_pulse(1, 1'b1);
      for (int i = 0; i < 6; i++) begin
         l = $urandom_range(1, SC + 20);
         pin_pulse(l, exp_short(l));
      end
      for (int b = 1; b <= 4; b++) begin
         src_req(b);
      end
      // oscillator late: settle must wait until it runs
      @(posedge ref_clk_i);
      osc_run <= 1'b0;
      sw_rst  <= 1'b1;
      @(posedge ref_clk_i);
      sw_rst <= 1'b0;
      repeat (SC + 4 + $urandom_range(0, 3)) @(posedge ref_clk_i);
      #1;
      check(vf, 1'b0);
      check(rst.cpu_rst, 1'b1);
      @(posedge ref_clk_i);
      osc_run <= 1'b1;
      wait_vec(n);
      check(n, 1);
      $display("test late oscillator done");
      // pin reset landing on a ram write leaves ram undefined
      check(st.ram_undefined, 1'b0);
      @(posedge ref_clk_i);
      ram_busy <= 1'b1;
      pin_pulse(SC + 2, 1'b0);
      ram_busy <= 1'b0;
      check(st.ram_undefined, 1'b1);
      $display("test ram write reset done");
      // mid-run reset clears the sticky ram flag and must not fake a short pulse
      @(posedge ref_clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      wait_vec(n);
      check(n < 200, 1'b1);
      check(st.ram_undefined, 1'b0);
      check(st.short_pulse, 1'b0);
      check(st.cause[0], 1'b1);
      $display("test mid-run reset done");
      summarize;
   end
endmodule
`default_nettype wire
